// File: src/twp_defs.svh
// register offsets, field positions, reset values and timing figures
`ifndef TWP_DEFS_SVH
`define TWP_DEFS_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define TWP_OFF_TIMER 8'h00
`define TWP_OFF_CTRL 8'h04
`define TWP_OFF_DIR5 8'h08
`define TWP_OFF_DIR6 8'h0c
`define TWP_OFF_DIR7 8'h10
`define TWP_OFF_WAKE6 8'h14
`define TWP_OFF_WSP 8'h18
`define TWP_OFF_IMASK 8'h1c
`define TWP_OFF_ISTAT 8'h20
`define TWP_OFF_DATA5 8'h24
`define TWP_OFF_DATA6 8'h28
`define TWP_OFF_DATA7 8'h2c
`define TWP_OFF_CMD 8'h30

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define TWP_CTRL_GIE 6
`define TWP_CTRL_SRC 5
`define TWP_CTRL_EDGE 4
`define TWP_CTRL_ASSIGN 3
`define TWP_WSP_ODE 6
`define TWP_WSP_WATCHDOG_ENABLE 5
`define TWP_WSP_DEEP_SLEEP_CONTROL 4
`define TWP_WSP_ROC 3
`define TWP_WSP_WAKE7 0
`define TWP_IRQ_EXT 3
`define TWP_IRQ_TMR 0
`define TWP_CMD_WATCHDOG_CLEAR_INSTR 0
`define TWP_CMD_SLEEP 1
`define TWP_CMD_ENI 2
`define TWP_CMD_IRQ_DISABLE_INSTR 3

// ----------------------------------------------------------------
// reset values and writable masks
// ----------------------------------------------------------------
`define TWP_RST_CTRL 8'hbf
`define TWP_RST_DIR 8'hff
`define TWP_RST_WAKE6 8'hff
`define TWP_RST_WSP 8'h31
`define TWP_RST_IMASK 8'h00
`define TWP_WSP_WMASK 8'h79
`define TWP_IMASK_WMASK 8'h09

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define TWP_CLK_KHZ 50000
`define TWP_OST_MS 18
`define TWP_WDT_MS 18

`endif

// File: src/twp_pkg.sv
// types shared by the timer, watchdog and port control block
package twp_pkg;

	typedef enum logic [1:0] {
		TWP_RUN,
		TWP_DEEP,
		TWP_LIGHT,
		TWP_START
	} twp_pwr_t;

	typedef struct packed {
		logic [7:0] dir;
		logic [7:0] data;
	} twp_port_t;

	typedef struct packed {
		logic [7:0] timer;
		logic [7:0] core_control;
		twp_port_t p5;
		twp_port_t p6;
		twp_port_t p7;
		logic [7:0] wake6;
		logic [7:0] wsp;
		logic [7:0] imask;
		logic tflag;
		logic eflag;
		logic [7:0] pin7_out;
		logic [7:0] pin7_oe_n;
		logic wr_pend;
		logic [7:0] wr_off;
		logic [31:0] rdata;
		logic hready;
		logic [1:0] div;
		logic instr_tick;
		logic [7:0] p5_s1;
		logic [7:0] p5_s2;
		logic [7:0] p6_s1;
		logic [7:0] p6_s2;
		logic [7:0] p7_s1;
		logic [7:0] p7_s2;
		logic [2:0] tpin;
		logic [2:0] epin;
		logic [1:0] wdopt;
		logic [1:0] clkopt;
		logic [23:0] wdt_cnt;
		logic [23:0] ost_cnt;
		twp_pwr_t pwr;
		logic wdt_rst;
		logic irq;
	} twp_state_t;

endpackage : twp_pkg

// File: src/twp_prescaler.sv
// shared 8-bit prescaler with power-of-two tap select
`timescale 1ns/10ps
module twp_prescaler #(
	parameter int WIDTH = 8
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic clear,
	input wire logic step,
	input wire logic [3:0] shift,
	output logic tick
);

	typedef struct packed {
		logic [WIDTH-1:0] cnt;
		logic tick;
	} twp_psc_t;

	twp_psc_t psc_reg;
	twp_psc_t psc_next;
	logic [WIDTH:0] mask;

	always_comb begin
		mask = ((WIDTH+1)'(1) << shift) - (WIDTH+1)'(1);
		psc_next = psc_reg;
		psc_next.tick = 1'b0;
		if (clear) begin
			psc_next.cnt = '0;
		end else if (step) begin
			psc_next.cnt = psc_reg.cnt + WIDTH'(1);
			// ratio is 2^shift steps per output tick
			if ((psc_reg.cnt & mask[WIDTH-1:0]) == mask[WIDTH-1:0]) begin
				psc_next.tick = 1'b1;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			psc_reg <= '0;
		end else begin
			psc_reg <= psc_next;
		end
	end

	assign tick = psc_reg.tick;

endmodule : twp_prescaler

// File: src/twp_top.sv
// timer/counter, watchdog, port direction and wake-up control block
//
// The register addresses and the AHB-Lite register port were left to the implementer.
`timescale 1ns/10ps
`include "twp_defs.svh"

// Contract
// [R1] direction bit 1 floats the pin as input, 0 drives it.
// [R2] port 6 wake bits: 0 enables pin wake-up, 1 disables it.
// [R3] bit 6 makes port 7 pins 6 and 7 open-drain when set.
// [R4] bit 5 enables watchdog only while watchdog code option is 0.
// [R5] deep-sleep bit: hardware sets on wake, software clears; 1-to-0 sleeps.
// [R6] every oscillator restart holds execution for an 18 ms start-up delay.
// [R7] bit 3 lets software read port 7 pins 0 and 1.
// [R8] bit 0 of watchdog control: 0 enables port 7 pins 4/5 wake.
// [R9] bits 1, 2 and 7 of watchdog control have no function.
// [R10] mask bit 3 enables external request, bit 0 timer overflow request.
// [R11] global enable set by enable command, cleared by disable command.
// [R12] one 8-bit prescaler serves timer or watchdog, never both.
// [R13] timer write clears prescaler when the prescaler belongs to the timer.
// [R14] watchdog clear and sleep clear watchdog and its prescaler.
// [R15] internal source: timer counts one per instruction cycle.
// [R16] instruction clock is core divided by 2, or by 4 with option set.
// [R17] external source: timer counts on the selected timer pin edge.
// [R18] watchdog keeps counting in sleep; timeout resets the device.
// [R19] unprescaled watchdog timeout is about 18 ms.
// [R20] pin-change wake on all port 6 pins and port 7 pins 4, 5.
// [R21] port data and direction registers are readable and writable.
// [R22] assignment bit 0 gives prescaler to timer, 1 to watchdog.
// [R23] ratio codes give timer 1:2 to 1:256, watchdog 1:1 to 1:128.
// [R24] source 0 internal, 1 pin; edge 0 rising, 1 falling.
// [R25] overflow flag set by hardware, cleared by software; reads masked.
// [R26] timer wraps from ff to 00 and that wrap is the overflow.
module twp_top #(
	parameter int OST_CYCLES = `TWP_OST_MS * `TWP_CLK_KHZ,
	parameter int WDT_CYCLES = `TWP_WDT_MS * `TWP_CLK_KHZ
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic [7:0] port5_in,
	output logic [7:0] port5_out,
	output logic [7:0] port5_oe_n,
	input wire logic [7:0] port6_in,
	output logic [7:0] port6_out,
	output logic [7:0] port6_oe_n,
	input wire logic [7:0] port7_in,
	output logic [7:0] port7_out,
	output logic [7:0] port7_oe_n,
	input wire logic timer_pin,
	input wire logic ext_int_n,
	input wire logic watchdog_code_option,
	input wire logic clock_code_option,
	output logic irq_request,
	output logic watchdog_reset,
	output logic osc_run,
	output logic exec_hold,
	output logic deep_sleep
);

	// ----------------------------------------------------------------
	// state and helpers
	// ----------------------------------------------------------------
	twp_pkg::twp_state_t s_reg;
	twp_pkg::twp_state_t s_next;

	logic psc_tick;
	logic psc_clear;
	logic psc_step;
	logic [3:0] psc_shift;
	logic to_wdt;
	logic timer_src;
	logic wdt_active;
	logic wdt_base;
	logic cmd_watchdog_clear_instr;
	logic cmd_sleep;

	// pin readback: inputs show the pin, outputs show the latch
	function automatic logic [7:0] port_read(input twp_pkg::twp_port_t p,
		input logic [7:0] pin);
		port_read = (p.dir & pin) | (~p.dir & p.data);
	endfunction : port_read

	function automatic logic is_off(input logic [7:0] off,
		input logic [7:0] ref_off);
		is_off = (off == ref_off);
	endfunction : is_off

	// ----------------------------------------------------------------
	// prescaler shared by timer and watchdog
	// ----------------------------------------------------------------
	assign to_wdt = s_reg.core_control[`TWP_CTRL_ASSIGN]; // see [R22]
	assign cmd_watchdog_clear_instr = s_reg.wr_pend && is_off(s_reg.wr_off, `TWP_OFF_CMD)
		&& hwdata[`TWP_CMD_WATCHDOG_CLEAR_INSTR];
	assign cmd_sleep = s_reg.wr_pend && is_off(s_reg.wr_off, `TWP_OFF_CMD)
		&& hwdata[`TWP_CMD_SLEEP];
	assign wdt_active = s_reg.wsp[`TWP_WSP_WATCHDOG_ENABLE]
		&& !s_reg.wdopt[1]; // see [R4]
	assign wdt_base = wdt_active
		&& (s_reg.wdt_cnt == 24'(WDT_CYCLES - 1)); // see [R19]

	// timer source: instruction tick or synchronised pin edge
	always_comb begin
		if (s_reg.core_control[`TWP_CTRL_SRC]) begin
			// see [R17] see [R24]
			if (s_reg.core_control[`TWP_CTRL_EDGE]) begin
				timer_src = s_reg.tpin[2] && !s_reg.tpin[1];
			end else begin
				timer_src = !s_reg.tpin[2] && s_reg.tpin[1];
			end
		end else begin
			timer_src = s_reg.instr_tick; // see [R15]
		end
	end

	// timer ratios are one tap longer than the watchdog ones
	assign psc_shift = to_wdt ? {1'b0, s_reg.core_control[2:0]}
		: {1'b0, s_reg.core_control[2:0]} + 4'h1; // see [R23]
	assign psc_step = to_wdt ? wdt_base : timer_src; // see [R12]
	assign psc_clear = to_wdt ? (cmd_watchdog_clear_instr || cmd_sleep) // see [R14]
		: (s_reg.wr_pend
		&& is_off(s_reg.wr_off, `TWP_OFF_TIMER)); // see [R13]

	twp_prescaler #(
		.WIDTH(8)
	) u_prescaler (
		.core_clk(core_clk),
		.rst(rst),
		.clear(psc_clear),
		.step(psc_step),
		.shift(psc_shift),
		.tick(psc_tick)
	);

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		logic [7:0] wd;
		logic tmr_inc;
		logic wake_hit;
		logic timeout;
		wd = hwdata[7:0];
		tmr_inc = 1'b0;
		wake_hit = 1'b0;
		timeout = 1'b0;
		s_next = s_reg;

		// two-flop synchronisers for every pin
		s_next.p5_s1 = port5_in;
		s_next.p5_s2 = s_reg.p5_s1;
		s_next.p6_s1 = port6_in;
		s_next.p6_s2 = s_reg.p6_s1;
		s_next.p7_s1 = port7_in;
		s_next.p7_s2 = s_reg.p7_s1;
		s_next.tpin = {s_reg.tpin[1:0], timer_pin};
		s_next.epin = {s_reg.epin[1:0], ext_int_n};
		s_next.wdopt = {s_reg.wdopt[0], watchdog_code_option};
		s_next.clkopt = {s_reg.clkopt[0], clock_code_option};

		// instruction clock divider, stopped with the oscillator
		s_next.instr_tick = 1'b0;
		if (s_reg.pwr == twp_pkg::TWP_RUN) begin
			if (s_reg.div == (s_reg.clkopt[1] ? 2'h3 : 2'h1)) begin
				s_next.div = 2'h0;
				s_next.instr_tick = 1'b1; // see [R16]
			end else begin
				s_next.div = s_reg.div + 2'h1;
			end
		end else begin
			s_next.div = 2'h0;
		end

		// ------------------------------------------------------------
		// register writes from the data phase
		// ------------------------------------------------------------
		if (s_reg.wr_pend) begin
			unique case (s_reg.wr_off)
				`TWP_OFF_TIMER: s_next.timer = wd;
				`TWP_OFF_CTRL: begin
					s_next.core_control = {wd[7], s_reg.core_control[`TWP_CTRL_GIE], wd[5:0]};
				end
				`TWP_OFF_DIR5: s_next.p5.dir = wd; // see [R21]
				`TWP_OFF_DIR6: s_next.p6.dir = wd;
				`TWP_OFF_DIR7: s_next.p7.dir = wd;
				`TWP_OFF_DATA5: s_next.p5.data = wd;
				`TWP_OFF_DATA6: s_next.p6.data = wd;
				`TWP_OFF_DATA7: s_next.p7.data = wd;
				`TWP_OFF_WAKE6: s_next.wake6 = wd;
				`TWP_OFF_WSP: s_next.wsp = wd & `TWP_WSP_WMASK; // see [R9]
				`TWP_OFF_IMASK: s_next.imask = wd & `TWP_IMASK_WMASK;
				`TWP_OFF_ISTAT: begin
					// write one to clear, hardware set below wins
					if (wd[`TWP_IRQ_TMR]) begin
						s_next.tflag = 1'b0;
					end
					if (wd[`TWP_IRQ_EXT]) begin
						s_next.eflag = 1'b0;
					end
				end
				`TWP_OFF_CMD: begin
					if (wd[`TWP_CMD_ENI]) begin
						s_next.core_control[`TWP_CTRL_GIE] = 1'b1; // see [R11]
					end
					if (wd[`TWP_CMD_IRQ_DISABLE_INSTR]) begin
						s_next.core_control[`TWP_CTRL_GIE] = 1'b0;
					end
				end
				default: begin
				end
			endcase
		end

		// ------------------------------------------------------------
		// timer/counter
		// ------------------------------------------------------------
		tmr_inc = to_wdt ? timer_src : psc_tick;
		if (tmr_inc && !(s_reg.wr_pend
			&& is_off(s_reg.wr_off, `TWP_OFF_TIMER))) begin
			s_next.timer = s_reg.timer + 8'h01; // see [R26]
			if (s_reg.timer == 8'hff) begin
				s_next.tflag = 1'b1; // see [R25]
			end
		end
		if (s_reg.epin[2] && !s_reg.epin[1]) begin
			s_next.eflag = 1'b1;
		end

		// ------------------------------------------------------------
		// watchdog, free running on its own count, also in sleep
		// ------------------------------------------------------------
		if (!wdt_active || cmd_watchdog_clear_instr || cmd_sleep) begin
			s_next.wdt_cnt = 24'h0; // see [R14]
		end else if (wdt_base) begin
			s_next.wdt_cnt = 24'h0;
		end else begin
			s_next.wdt_cnt = s_reg.wdt_cnt + 24'h1; // see [R18]
		end
		timeout = to_wdt ? psc_tick : wdt_base;
		s_next.wdt_rst = wdt_active && timeout; // see [R18]

		// ------------------------------------------------------------
		// wake-up detection and power sequencing
		// ------------------------------------------------------------
		wake_hit = |(~s_reg.p6_s2 & ~s_reg.wake6) // see [R2] see [R20]
			|| (|(~s_reg.p7_s2[5:4])
			&& !s_reg.wsp[`TWP_WSP_WAKE7]); // see [R8]

		unique case (s_reg.pwr)
			twp_pkg::TWP_RUN: begin
				if (cmd_sleep) begin
					s_next.pwr = twp_pkg::TWP_LIGHT;
				end else if (s_reg.wsp[`TWP_WSP_DEEP_SLEEP_CONTROL]
					&& !s_next.wsp[`TWP_WSP_DEEP_SLEEP_CONTROL]) begin
					s_next.pwr = twp_pkg::TWP_DEEP; // see [R5]
				end
			end
			twp_pkg::TWP_DEEP: begin
				if (wake_hit || s_next.wsp[`TWP_WSP_DEEP_SLEEP_CONTROL]) begin
					s_next.wsp[`TWP_WSP_DEEP_SLEEP_CONTROL] = 1'b1; // see [R5]
					if (!s_reg.wdopt[1]) begin
						s_next.wsp[`TWP_WSP_WATCHDOG_ENABLE] = 1'b1;
					end
					s_next.ost_cnt = 24'h0;
					s_next.pwr = twp_pkg::TWP_START;
				end
			end
			twp_pkg::TWP_LIGHT: begin
				// only a device reset ends this sleep
			end
			twp_pkg::TWP_START: begin
				if (s_reg.ost_cnt == 24'(OST_CYCLES - 1)) begin
					s_next.pwr = twp_pkg::TWP_RUN; // see [R6]
				end else begin
					s_next.ost_cnt = s_reg.ost_cnt + 24'h1;
				end
			end
		endcase

		// ------------------------------------------------------------
		// pin drivers and interrupt request
		// ------------------------------------------------------------
		s_next.pin7_out = s_next.p7.data;
		s_next.pin7_oe_n = s_next.p7.dir; // see [R1]
		if (s_next.wsp[`TWP_WSP_ODE]) begin
			// open drain: drive only a low, float a high
			s_next.pin7_out[7:6] = 2'b00; // see [R3]
			s_next.pin7_oe_n[7:6] = s_next.p7.dir[7:6]
				| s_next.p7.data[7:6];
		end
		s_next.irq = s_next.core_control[`TWP_CTRL_GIE] // see [R11]
			&& ((s_next.tflag && s_next.imask[`TWP_IRQ_TMR])
			|| (s_next.eflag && s_next.imask[`TWP_IRQ_EXT])); // see [R10]

		// ------------------------------------------------------------
		// bus address phase and read data
		// ------------------------------------------------------------
		s_next.hready = 1'b1;
		s_next.wr_pend = hsel && htrans[1] && hready && hwrite;
		s_next.wr_off = {haddr[7:2], 2'b00};
		if (hsel && htrans[1] && hready && !hwrite) begin
			s_next.rdata = 32'h0;
			unique case ({haddr[7:2], 2'b00})
				`TWP_OFF_TIMER: s_next.rdata[7:0] = s_next.timer;
				`TWP_OFF_CTRL: s_next.rdata[7:0] = s_next.core_control;
				`TWP_OFF_DIR5: s_next.rdata[7:0] = s_next.p5.dir;
				`TWP_OFF_DIR6: s_next.rdata[7:0] = s_next.p6.dir;
				`TWP_OFF_DIR7: s_next.rdata[7:0] = s_next.p7.dir;
				`TWP_OFF_DATA5: begin
					s_next.rdata[7:0] = port_read(s_next.p5, s_reg.p5_s2);
				end
				`TWP_OFF_DATA6: begin
					s_next.rdata[7:0] = port_read(s_next.p6, s_reg.p6_s2);
				end
				`TWP_OFF_DATA7: begin
					s_next.rdata[7:0] = port_read(s_next.p7, s_reg.p7_s2);
					// option pins read the pin only while the option is on
					if (s_next.wsp[`TWP_WSP_ROC]) begin
						s_next.rdata[1:0] = s_reg.p7_s2[1:0]; // see [R7]
					end else begin
						s_next.rdata[1:0] = s_next.p7.data[1:0];
					end
				end
				`TWP_OFF_WAKE6: s_next.rdata[7:0] = s_next.wake6;
				`TWP_OFF_WSP: s_next.rdata[7:0] = s_next.wsp;
				`TWP_OFF_IMASK: s_next.rdata[7:0] = s_next.imask;
				`TWP_OFF_ISTAT: begin
					s_next.rdata[`TWP_IRQ_TMR] = s_next.tflag
						&& s_next.imask[`TWP_IRQ_TMR]; // see [R25]
					s_next.rdata[`TWP_IRQ_EXT] = s_next.eflag
						&& s_next.imask[`TWP_IRQ_EXT];
				end
				default: begin
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// state register
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (rst) begin
			s_reg <= '0;
			s_reg.core_control <= `TWP_RST_CTRL;
			s_reg.p5.dir <= `TWP_RST_DIR;
			s_reg.p6.dir <= `TWP_RST_DIR;
			s_reg.p7.dir <= `TWP_RST_DIR;
			s_reg.pin7_oe_n <= `TWP_RST_DIR;
			s_reg.wake6 <= `TWP_RST_WAKE6;
			s_reg.wsp <= `TWP_RST_WSP;
			s_reg.imask <= `TWP_RST_IMASK;
			s_reg.hready <= 1'b1;
			s_reg.tpin <= 3'h7;
			s_reg.epin <= 3'h7;
			s_reg.p6_s1 <= 8'hff;
			s_reg.p6_s2 <= 8'hff;
			s_reg.p7_s1 <= 8'hff;
			s_reg.p7_s2 <= 8'hff;
			s_reg.pwr <= twp_pkg::TWP_START; // see [R6]
		end else begin
			s_reg <= s_next;
		end
	end

	// ----------------------------------------------------------------
	// outputs, all straight from the state register
	// ----------------------------------------------------------------
	assign hreadyout = s_reg.hready;
	assign hresp = 1'b0 & s_reg.hready;
	assign hrdata = s_reg.rdata;
	assign port5_out = s_reg.p5.data;
	assign port5_oe_n = s_reg.p5.dir;
	assign port6_out = s_reg.p6.data;
	assign port6_oe_n = s_reg.p6.dir;
	assign port7_out = s_reg.pin7_out;
	assign port7_oe_n = s_reg.pin7_oe_n;
	assign irq_request = s_reg.irq;
	assign watchdog_reset = s_reg.wdt_rst;
	assign osc_run = (s_reg.pwr == twp_pkg::TWP_RUN)
		|| (s_reg.pwr == twp_pkg::TWP_START);
	assign exec_hold = (s_reg.pwr != twp_pkg::TWP_RUN);
	assign deep_sleep = (s_reg.pwr == twp_pkg::TWP_DEEP);

endmodule : twp_top

// File: testbench/tb.sv
// self-checking bench for the timer, watchdog and port control block
`timescale 1ns/10ps
`include "twp_defs.svh"
module tb;
	localparam int OSC_STARTUP_DELAY = 20;
	localparam int WDT = 40;
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic [7:0] p5_in = 8'h00;
	logic [7:0] p6_in = 8'hff;
	logic [7:0] p7_in = 8'hff;
	logic tpin = 1'b1;
	logic ext_n = 1'b1;
	logic wopt = 1'b1;
	logic copt = 1'b0;
	wire hrdy;
	wire [31:0] hrdata;
	wire [7:0] p5_out, p5_oe_n, p6_out, p6_oe_n, p7_out, p7_oe_n;
	wire irq, wdr, osc, hold, dsl;
	int fails = 0;
	int n_checks = 0;
	int pulses = 0;
	logic [31:0] q;
	twp_top #(.OST_CYCLES(OSC_STARTUP_DELAY), .WDT_CYCLES(WDT)) dut_u (
		.core_clk(core_clk), .rst(rst), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hrdy), .hreadyout(hrdy), .hresp(), .hrdata(hrdata),
		.port5_in(p5_in), .port5_out(p5_out), .port5_oe_n(p5_oe_n),
		.port6_in(p6_in), .port6_out(p6_out), .port6_oe_n(p6_oe_n),
		.port7_in(p7_in), .port7_out(p7_out), .port7_oe_n(p7_oe_n),
		.timer_pin(tpin), .ext_int_n(ext_n),
		.watchdog_code_option(wopt), .clock_code_option(copt),
		.irq_request(irq), .watchdog_reset(wdr), .osc_run(osc),
		.exec_hold(hold), .deep_sleep(dsl)
	);
	initial forever #10 core_clk = ~core_clk;
	always @(negedge core_clk) if (wdr === 1'b1) pulses++;
	// ----------------------------------------------------------------
	// bus and check tasks
	// ----------------------------------------------------------------
	task automatic chk(input logic [31:0] g, input logic [31:0] e,
		input string m);
		n_checks++;
		if (g !== e) begin
			fails++;
			$display("[FAIL] %0t %s got %h exp %h", $time, m, g, e);
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
	endtask : cyc
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [7:0] d);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		hwrite <= w;
		htrans <= 2'h2;
		do @(posedge core_clk); while (hrdy !== 1'b1);
		htrans <= 2'h0;
		hwdata <= {24'h0, d};
		do @(posedge core_clk); while (hrdy !== 1'b1);
		q = hrdata;
	endtask : bus
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		bus(1'b1, a, d);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] e,
		input string m);
		bus(1'b0, a, 8'h00);
		chk(q, {24'h0, e}, m);
	endtask : rd
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : tally_and_finish
	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_reset;
		chk({24'h0, p5_oe_n}, 32'hff, "oe5 reset");
		rd(`TWP_OFF_CTRL, 8'hbf, "ctrl");
		rd(`TWP_OFF_DIR6, 8'hff, "dir6");
		rd(`TWP_OFF_WAKE6, 8'hff, "wake6");
		rd(`TWP_OFF_WSP, 8'h31, "wsp");
		rd(`TWP_OFF_IMASK, 8'h00, "imask");
		wr(8'h3c, 8'hff);
		rd(8'h3c, 8'h00, "unmapped");
		$display("reset test done");
	endtask : t_reset
	task automatic t_regs;
		wr(`TWP_OFF_DIR5, 8'h5a);
		wr(`TWP_OFF_DATA5, 8'ha5);
		cyc(1);
		chk({p5_oe_n, p5_out}, 32'h5aa5, "port5");
		rd(`TWP_OFF_DIR5, 8'h5a, "dir5");
		wr(`TWP_OFF_WAKE6, 8'h3c);
		rd(`TWP_OFF_WAKE6, 8'h3c, "wake6");
		wr(`TWP_OFF_IMASK, 8'hff);
		rd(`TWP_OFF_IMASK, 8'h09, "imask");
		p7_in <= 8'h00;
		wr(`TWP_OFF_DIR7, 8'h00);
		wr(`TWP_OFF_DATA7, 8'hff);
		wr(`TWP_OFF_WSP, 8'hff);
		rd(`TWP_OFF_WSP, 8'h79, "unused bits");
		chk({p7_out[7:6], p7_oe_n[7:6]}, 32'h3, "open drain");
		rd(`TWP_OFF_DATA7, 8'hfc, "roption on");
		wr(`TWP_OFF_WSP, 8'h31);
		cyc(1);
		chk({p7_out, p7_oe_n}, 32'hff00, "push pull");
		rd(`TWP_OFF_DATA7, 8'hff, "roption off");
		$display("register test done");
	endtask : t_regs
	task automatic t_irq;
		logic [7:0] v;
		wr(`TWP_OFF_CTRL, 8'h08);
		for (int c = 0; c < 2; c++) begin
			copt <= c[0];
			cyc(4);
			bus(1'b0, `TWP_OFF_TIMER, 8'h00);
			v = q[7:0];
			cyc(14);
			bus(1'b0, `TWP_OFF_TIMER, 8'h00);
			chk({24'h0, q[7:0] - v}, c ? 32'h4 : 32'h8, "rate");
		end
		copt <= 1'b0;
		wr(`TWP_OFF_IMASK, 8'h01);
		wr(`TWP_OFF_TIMER, 8'hfe);
		cyc(8);
		rd(`TWP_OFF_ISTAT, 8'h01, "overflow");
		chk({31'h0, irq}, 32'h0, "irq gated");
		wr(`TWP_OFF_CMD, 8'h04);
		cyc(2);
		chk({31'h0, irq}, 32'h1, "irq on");
		wr(`TWP_OFF_IMASK, 8'h00);
		rd(`TWP_OFF_ISTAT, 8'h00, "masked");
		chk({31'h0, irq}, 32'h0, "irq masked");
		wr(`TWP_OFF_IMASK, 8'h01);
		wr(`TWP_OFF_CMD, 8'h08);
		cyc(2);
		chk({31'h0, irq}, 32'h0, "irq off");
		wr(`TWP_OFF_ISTAT, 8'h01);
		rd(`TWP_OFF_ISTAT, 8'h00, "flag clear");
		wr(`TWP_OFF_IMASK, 8'h08);
		ext_n <= 1'b0;
		cyc(4);
		ext_n <= 1'b1;
		rd(`TWP_OFF_ISTAT, 8'h08, "ext flag");
		$display("timer irq test done");
	endtask : t_irq
	task automatic t_presc;
		for (int r = 0; r < 8; r++) begin
			wr(`TWP_OFF_CTRL, r[7:0]);
			wr(`TWP_OFF_TIMER, 8'h00);
			cyc((18 << r) - 1);
			rd(`TWP_OFF_TIMER, 8'h04, "ratio");
		end
		for (int e = 0; e < 2; e++) begin
			wr(`TWP_OFF_CTRL, e ? 8'h38 : 8'h28);
			wr(`TWP_OFF_TIMER, 8'h00);
			repeat (3) begin
				tpin <= ~tpin;
				cyc(4);
				tpin <= ~tpin;
				cyc(4);
			end
			rd(`TWP_OFF_TIMER, 8'h03, "pin edges");
		end
		$display("prescaler test done");
	endtask : t_presc
	task automatic t_wdt;
		int p0;
		wr(`TWP_OFF_CTRL, 8'h00);
		wopt <= 1'b0;
		wr(`TWP_OFF_CMD, 8'h01);
		p0 = pulses;
		cyc(WDT - 6);
		chk(pulses - p0, 32'h0, "early bark");
		cyc(12);
		chk(pulses - p0, 32'h1, "timeout");
		repeat (4) begin
			wr(`TWP_OFF_CMD, 8'h01);
			cyc(WDT / 2);
		end
		chk(pulses - p0, 32'h1, "cleared");
		wr(`TWP_OFF_WSP, 8'h11);
		cyc(WDT * 2);
		chk(pulses - p0, 32'h1, "bit off");
		wopt <= 1'b1;
		cyc(3);
		wr(`TWP_OFF_WSP, 8'h31);
		cyc(WDT * 2);
		chk(pulses - p0, 32'h1, "option off");
		wr(`TWP_OFF_CTRL, 8'h09);
		wopt <= 1'b0;
		wr(`TWP_OFF_CMD, 8'h01);
		cyc(WDT * 2 - 8);
		chk(pulses - p0, 32'h1, "scaled early");
		cyc(16);
		chk(pulses - p0, 32'h2, "scaled");
		wopt <= 1'b1;
		cyc(3);
		$display("watchdog test done");
	endtask : t_wdt
	task automatic t_deep;
		p7_in <= 8'hff;
		wr(`TWP_OFF_WAKE6, 8'hfe);
		wr(`TWP_OFF_WSP, 8'h21);
		cyc(2);
		chk({dsl, osc}, 32'h2, "deep");
		p6_in <= 8'hfd;
		p7_in <= 8'h00;
		cyc(8);
		chk({31'h0, dsl}, 32'h1, "masked wake");
		p6_in <= 8'hfe;
		cyc(6);
		chk({dsl, osc, hold}, 32'h3, "port6 wake");
		cyc(OSC_STARTUP_DELAY);
		chk({31'h0, hold}, 32'h0, "start-up");
		rd(`TWP_OFF_WSP, 8'h31, "set by wake");
		p6_in <= 8'hff;
		p7_in <= 8'hff;
		wr(`TWP_OFF_WSP, 8'h20);
		cyc(2);
		chk({31'h0, dsl}, 32'h1, "deep again");
		p7_in <= 8'hdf;
		cyc(6);
		chk({dsl, osc, hold}, 32'h3, "port7 wake");
		cyc(OSC_STARTUP_DELAY);
		wr(`TWP_OFF_CMD, 8'h02);
		cyc(2);
		chk({dsl, osc, hold}, 32'h1, "light sleep");
		rst <= 1'b1;
		cyc(6);
		rst <= 1'b0;
		cyc(OSC_STARTUP_DELAY + 4);
		chk({31'h0, hold}, 32'h0, "reset start-up");
		$display("sleep test done");
	endtask : t_deep
	initial begin
		cyc(6);
		rst <= 1'b0;
		cyc(1);
		t_reset;
		t_regs;
		t_irq;
		t_presc;
		t_wdt;
		t_deep;
		tally_and_finish;
	end
	initial begin
		cyc(20000);
		fails++;
		tally_and_finish;
	end
endmodule : tb

// File: testbench/twp_properties.sv
// concurrent checks on the ports of the timer and port control block
`timescale 1ns/10ps
module twp_properties #(
	parameter int OST_CYCLES = 20,
	parameter int WDT_CYCLES = 40
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic [7:0] port5_out,
	input wire logic [7:0] port5_oe_n,
	input wire logic [7:0] port7_out,
	input wire logic watchdog_code_option,
	input wire logic irq_request,
	input wire logic watchdog_reset,
	input wire logic osc_run,
	input wire logic exec_hold,
	input wire logic deep_sleep
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	// ----------------------------------------------------------------
	// helper state: bus data phase, open-drain bit, start-up length
	// ----------------------------------------------------------------
	logic wp_reg;
	logic [5:0] wo_reg;
	logic ode_reg;
	int st_reg;
	always_ff @(posedge core_clk) begin
		wp_reg <= !rst && hsel && htrans[1] && hready && hwrite;
		wo_reg <= haddr[7:2];
		if (rst)
			ode_reg <= 1'b0;
		else if (wp_reg && wo_reg == 6'h06)
			ode_reg <= hwdata[6];
		st_reg <= (!rst && osc_run && exec_hold) ? st_reg + 1 : 0;
	end
	// ----------------------------------------------------------------
	// properties
	// ----------------------------------------------------------------
	sequence s_wr(logic [5:0] off);
		hsel && htrans[1] && hready && hwrite && haddr[7:2] == off ##1 1'b1;
	endsequence
	sequence s_start;
		osc_run && exec_hold;
	endsequence
	property p_dir5;
		s_wr(6'h02) |=> {24'h0, port5_oe_n} == ($past(hwdata) & 32'hff);
	endproperty
	property p_dat5;
		s_wr(6'h09) |=> {24'h0, port5_out} == ($past(hwdata) & 32'hff);
	endproperty
	property p_ode;
		ode_reg |-> port7_out[7:6] == 2'b00;
	endproperty
	property p_irq_disable_instr;
		s_wr(6'h0c) ##0 hwdata[3] |-> ##[1:2] !irq_request;
	endproperty
	property p_wdp;
		$rose(watchdog_reset) |=> !watchdog_reset;
	endproperty
	property p_opt;
		watchdog_code_option [*5] |-> !watchdog_reset;
	endproperty
	property p_deep;
		deep_sleep |-> !osc_run && exec_hold;
	endproperty
	property p_wake;
		$fell(deep_sleep) |-> s_start [*8];
	endproperty
	property p_ost;
		$fell(exec_hold) |-> st_reg >= OST_CYCLES - 2 && st_reg <= OST_CYCLES + 2;
	endproperty
	a_dir5: assert property (p_dir5) else $error("direction mismatch");
	a_dat5: assert property (p_dat5) else $error("data mismatch");
	a_ode: assert property (p_ode) else $error("open drain high");
	a_irq_disable_instr: assert property (p_irq_disable_instr) else $error("irq after off");
	a_wdp: assert property (p_wdp) else $error("long pulse");
	a_opt: assert property (p_opt) else $error("watchdog not off");
	a_deep: assert property (p_deep) else $error("clock in sleep");
	a_wake: assert property (p_wake) else $error("no start hold");
	a_ost: assert property (p_ost) else $error("start-up length");
endmodule : twp_properties

bind twp_top twp_properties #(.OST_CYCLES(OST_CYCLES),
	.WDT_CYCLES(WDT_CYCLES)) chk_u (.core_clk(core_clk), .rst(rst),
	.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
	.hwdata(hwdata), .hready(hready), .port5_out(port5_out),
	.port5_oe_n(port5_oe_n), .port7_out(port7_out),
	.watchdog_code_option(watchdog_code_option), .irq_request(irq_request),
	.watchdog_reset(watchdog_reset), .osc_run(osc_run),
	.exec_hold(exec_hold), .deep_sleep(deep_sleep));
